// ==== rtl/rscq_port.sv ====
// Command port: configuration writes, save and restore, query answers
module rscq_port
  import rscq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_frame,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  output logic o_rx_ready,
  input wire logic i_spi_sel,
  input wire logic i_rd_req,
  output logic o_rd_valid,
  output logic [7:0] o_rd_byte,
  input wire logic [55:0] i_cur_freq,
  input wire logic [55:0] i_sweep_start,
  input wire logic [55:0] i_sweep_stop,
  input wire logic [55:0] i_sweep_step,
  input wire logic [31:0] i_dwell,
  input wire logic [31:0] i_cycles,
  input wire logic [31:0] i_list_pts,
  input wire logic [31:0] i_phase_float,
  input wire logic [31:0] i_level_float,
  input wire logic [15:0] i_sensor_adc,
  input wire logic [31:0] i_temp_float,
  input wire logic [31:0] i_status,
  input wire logic [63:0] i_info,
  input wire logic [63:0] i_list_entry,
  input wire logic [15:0] i_dac_coarse,
  input wire logic [15:0] i_dac_fine,
  input wire logic [31:0] i_sensor_reading,
  output logic [11:0] o_list_addr,
  output logic o_cal_start,
  output logic o_cal_fine,
  output logic o_sensor_enable,
  output logic o_sensor_envelope,
  output logic [15:0] o_sensor_averages,
  output logic [55:0] o_sensor_freq,
  output logic o_busy
);
  import rscq_pkg::*;

  // ********************
  // State
  // ********************
  rscq_state_type st_q, st_d;
  logic [7:0] addr_q;
  logic [2:0] cnt_q;
  logic [55:0] data_q;
  logic [1:0] nvm_cnt_q;
  logic [23:0] setup_q;
  logic [55:0] sfreq_q;
  logic [63:0] stage_q;
  logic stage_full_q;
  logic [63:0] rdbuf_q;
  logic [7:0] rd_byte_q;
  logic rd_valid_q;
  logic cal_start_q;
  logic cal_fine_q;
  logic [11:0] list_addr_q;
  logic [NVM_DW-1:0] nvm_rdata;

  // ********************
  // Byte parser decode
  // ********************
  wire busy = (st_q == ST_SAVE) || (st_q == ST_LOAD) || (st_q == ST_LIST);
  wire take = i_frame && i_rx_valid && !busy;
  wire [2:0] len_now = len_of(addr_q);
  wire [55:0] data_nx = {data_q[47:0], i_rx_byte};
  wire fire = take && (st_q == ST_DATA) && (cnt_q == len_now - 3'd1);
  wire do_save = fire && (addr_q == ADDR_SAVE) && (data_nx[7:0] == 8'h00);
  wire do_cal = fire && (addr_q == ADDR_SELFCAL);
  wire do_setup = fire && (addr_q == ADDR_SETUP);
  wire do_sfreq = fire && (addr_q == ADDR_SFREQ);
  wire do_list = fire && (addr_q == ADDR_LISTQ);
  wire do_drain = fire && (addr_q == ADDR_DRAIN) && stage_full_q;
  wire is_query = (addr_q == ADDR_RFQ) || (addr_q == ADDR_TEMPQ) || (addr_q == ADDR_STATQ) ||
                  (addr_q == ADDR_INFOQ) || (addr_q == ADDR_DACQ) || (addr_q == ADDR_SENSQ);
  wire load_imm = fire && is_query;
  wire load_list = (st_q == ST_LIST);
  wire load = load_imm || load_list;

  // ********************
  // Answer selection
  // ********************
  logic [63:0] rf_resp;
  always_comb begin
    unique case (data_nx[RF_CODE_MSB:0])
      RF_CUR: rf_resp = {8'h00, i_cur_freq};
      RF_START: rf_resp = {8'h00, i_sweep_start};
      RF_STOP: rf_resp = {8'h00, i_sweep_stop};
      RF_STEP: rf_resp = {8'h00, i_sweep_step};
      RF_DWELL: rf_resp = {32'h00000000, i_dwell};
      RF_CYCLES: rf_resp = {32'h00000000, i_cycles};
      RF_PTS: rf_resp = {32'h00000000, i_list_pts};
      RF_PHASE: rf_resp = {32'h00000000, i_phase_float};
      RF_LEVEL: rf_resp = {32'h00000000, i_level_float};
      RF_SFREQ: rf_resp = {8'h00, sfreq_q};
      RF_ADC: rf_resp = {48'h000000000000, i_sensor_adc};
      default: rf_resp = 64'h0000000000000000;
    endcase
  end

  logic [63:0] resp;
  always_comb begin
    if (load_list) begin
      resp = i_list_entry;
    end else begin
      unique case (addr_q)
        ADDR_RFQ: resp = rf_resp;
        ADDR_TEMPQ: resp = {32'h00000000, i_temp_float};
        ADDR_STATQ: resp = {32'h00000000, i_status};
        ADDR_INFOQ: resp = i_info;
        ADDR_DACQ: resp = {48'h000000000000, data_nx[SEL_BIT] ? i_dac_fine : i_dac_coarse};
        ADDR_SENSQ: resp = {32'h00000000, i_sensor_reading};
        default: resp = 64'h0000000000000000;
      endcase
    end
  end

  // ********************
  // Sequencer
  // ********************
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (take) st_d = (len_of(i_rx_byte) == 3'd0) ? ST_SKIP : ST_DATA;
      ST_DATA: begin
        if (!i_frame) st_d = ST_IDLE;
        else if (do_save) st_d = ST_SAVE;
        else if (do_list) st_d = ST_LIST;
        else if (fire) st_d = ST_SKIP;
      end
      ST_SKIP: if (!i_frame) st_d = ST_IDLE;
      ST_LIST: st_d = i_frame ? ST_SKIP : ST_IDLE;
      ST_SAVE: if (nvm_cnt_q == NVM_LAST) st_d = i_frame ? ST_SKIP : ST_IDLE;
      ST_LOAD: if (nvm_cnt_q == LOAD_LAST) st_d = i_frame ? ST_SKIP : ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= ST_LOAD;
      nvm_cnt_q <= 2'h0;
    end else begin
      st_q <= st_d;
      nvm_cnt_q <= (st_q == ST_SAVE || st_q == ST_LOAD) ? nvm_cnt_q + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      addr_q <= 8'h00;
      cnt_q <= 3'h0;
      data_q <= 56'h00000000000000;
    end else if (take) begin
      if (st_q == ST_IDLE) begin
        addr_q <= i_rx_byte;
        cnt_q <= 3'h0;
        data_q <= 56'h00000000000000;
      end else if (st_q == ST_DATA) begin
        cnt_q <= cnt_q + 3'h1;
        data_q <= data_nx;
      end
    end
  end

  // ********************
  // Saved configuration
  // ********************
  wire nvm_we = (st_q == ST_SAVE);
  wire [NVM_DW-1:0] nvm_wdata = (nvm_cnt_q == 2'h0) ? {8'h00, setup_q} :
                                (nvm_cnt_q == 2'h1) ? sfreq_q[31:0] : {8'h00, sfreq_q[55:32]};
  wire cap_ok = (st_q == ST_LOAD) && (nvm_cnt_q != 2'h0);
  wire [1:0] cap_idx = nvm_cnt_q - 2'h1;

  rscq_nvm u_nvm (
    .i_clk(i_clk),
    .i_we(nvm_we),
    .i_addr(nvm_cnt_q),
    .i_wdata(nvm_wdata),
    .o_rdata(nvm_rdata)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      setup_q <= SETUP_RST;
      sfreq_q <= SFREQ_RST;
    end else if (cap_ok) begin
      if (cap_idx == 2'h0) setup_q <= nvm_rdata[23:0];
      if (cap_idx == 2'h1) sfreq_q[31:0] <= nvm_rdata;
      if (cap_idx == 2'h2) sfreq_q[55:32] <= nvm_rdata[23:0];
    end else begin
      if (do_setup) setup_q <= data_nx[23:0];
      if (do_sfreq) sfreq_q <= data_nx;
    end
  end

  // ********************
  // Calibration and list address
  // ********************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cal_start_q <= 1'b0;
      cal_fine_q <= 1'b0;
      list_addr_q <= 12'h000;
    end else begin
      cal_start_q <= do_cal;
      if (do_cal) cal_fine_q <= data_nx[SEL_BIT];
      if (do_list) list_addr_q <= {data_nx[11:8], data_nx[23:16]};
    end
  end

  // ********************
  // Answer buffers
  // ********************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage_q <= 64'h0000000000000000;
      stage_full_q <= 1'b0;
    end else if (load && i_spi_sel) begin
      stage_q <= resp;
      stage_full_q <= 1'b1;
    end else if (do_drain) begin
      stage_q <= 64'h0000000000000000;
      stage_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdbuf_q <= 64'h0000000000000000;
      rd_byte_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= i_rd_req;
      if (i_rd_req) rd_byte_q <= rdbuf_q[63:56];
      if (load && !i_spi_sel) rdbuf_q <= resp;
      else if (do_drain) rdbuf_q <= stage_q;
      else if (i_rd_req) rdbuf_q <= {rdbuf_q[55:0], 8'h00};
    end
  end

  assign o_rx_ready = !busy;
  assign o_rd_valid = rd_valid_q;
  assign o_rd_byte = rd_byte_q;
  assign o_list_addr = list_addr_q;
  assign o_cal_start = cal_start_q;
  assign o_cal_fine = cal_fine_q;
  assign o_sensor_enable = setup_q[SETUP_EN_BIT];
  assign o_sensor_envelope = setup_q[SETUP_MODE_BIT];
  assign o_sensor_averages = setup_q[SETUP_AVG_MSB:SETUP_AVG_LSB];
  assign o_sensor_freq = sfreq_q;
  assign o_busy = busy;

  // ********************
  // Checks
  // ********************
  sequence s_save_walk;
    nvm_we [*3] ##1 !nvm_we;
  endsequence
  property p_save;
    @(posedge i_clk) disable iff (i_rst) do_save |=> s_save_walk;
  endproperty
  a_save: assert property (p_save) else $error("save did not write three words");

  sequence s_load_walk;
    (st_q == ST_LOAD) [*4] ##1 (st_q != ST_LOAD);
  endsequence
  property p_restore;
    @(posedge i_clk) disable iff (i_rst) $fell(i_rst) |-> s_load_walk;
  endproperty
  a_restore: assert property (p_restore) else $error("restore did not run four cycles");

  property p_cal;
    @(posedge i_clk) disable iff (i_rst) do_cal |=> o_cal_start && (o_cal_fine == $past(data_nx[0]));
  endproperty
  a_cal: assert property (p_cal) else $error("calibration start or select wrong");

  property p_setup;
    @(posedge i_clk) disable iff (i_rst)
      do_setup |=> (o_sensor_averages == $past(data_nx[23:8])) && (o_sensor_envelope == $past(data_nx[1]))
                   && (o_sensor_enable == $past(data_nx[0]));
  endproperty
  a_setup: assert property (p_setup) else $error("sensor setup not applied");

  property p_sfreq;
    @(posedge i_clk) disable iff (i_rst) do_sfreq |=> (o_sensor_freq == $past(data_nx));
  endproperty
  a_sfreq: assert property (p_sfreq) else $error("correction frequency not applied");

  property p_msb_first;
    @(posedge i_clk) disable iff (i_rst) i_rd_req |=> o_rd_valid && (o_rd_byte == $past(rdbuf_q[63:56]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("read byte not the top byte");

  property p_eight;
    @(posedge i_clk) disable iff (i_rst) (i_rd_req && !load && !do_drain) [*8] |=> (rdbuf_q == 64'h0);
  endproperty
  a_eight: assert property (p_eight) else $error("buffer not empty after eight reads");

  property p_phase;
    @(posedge i_clk) disable iff (i_rst)
      (load_imm && !i_spi_sel && addr_q == ADDR_RFQ && data_nx[3:0] == RF_PHASE)
      |=> (rdbuf_q == {32'h0, $past(i_phase_float)});
  endproperty
  a_phase: assert property (p_phase) else $error("phase answer wrong");

  property p_temp;
    @(posedge i_clk) disable iff (i_rst)
      (load_imm && !i_spi_sel && addr_q == ADDR_TEMPQ) |=> (rdbuf_q[63:32] == 32'h0);
  endproperty
  a_temp: assert property (p_temp) else $error("temperature upper word not zero");

  property p_drain;
    @(posedge i_clk) disable iff (i_rst)
      do_drain |=> !stage_full_q && (rdbuf_q == $past(stage_q));
  endproperty
  a_drain: assert property (p_drain) else $error("drain did not move staged answer");
endmodule

// ==== rtl/rscq_pkg.sv ====
// Constants and types of the configuration and query port
package rscq_pkg;
  // ********************
  // Register addresses
  // ********************
  localparam logic [7:0] ADDR_SAVE = 8'h1B;
  localparam logic [7:0] ADDR_SELFCAL = 8'h1C;
  localparam logic [7:0] ADDR_SETUP = 8'h1D;
  localparam logic [7:0] ADDR_SFREQ = 8'h1E;
  localparam logic [7:0] ADDR_RFQ = 8'h20;
  localparam logic [7:0] ADDR_TEMPQ = 8'h21;
  localparam logic [7:0] ADDR_STATQ = 8'h22;
  localparam logic [7:0] ADDR_INFOQ = 8'h23;
  localparam logic [7:0] ADDR_LISTQ = 8'h24;
  localparam logic [7:0] ADDR_DACQ = 8'h25;
  localparam logic [7:0] ADDR_DRAIN = 8'h26;
  localparam logic [7:0] ADDR_RSVD = 8'h27;
  localparam logic [7:0] ADDR_SENSQ = 8'h28;
  // ********************
  // Fields and resets
  // ********************
  localparam int SEL_BIT = 0;
  localparam int SETUP_EN_BIT = 0;
  localparam int SETUP_MODE_BIT = 1;
  localparam int SETUP_AVG_LSB = 8;
  localparam int SETUP_AVG_MSB = 23;
  localparam int RF_CODE_MSB = 3;
  localparam int LIST_ADDR_MSB = 11;
  localparam int RESP_BYTES = 8;
  localparam logic [23:0] SETUP_RST = 24'h000000;
  localparam logic [55:0] SFREQ_RST = 56'h00000000000000;
  // ********************
  // Parameter codes
  // ********************
  localparam logic [3:0] RF_CUR = 4'h0;
  localparam logic [3:0] RF_START = 4'h1;
  localparam logic [3:0] RF_STOP = 4'h2;
  localparam logic [3:0] RF_STEP = 4'h3;
  localparam logic [3:0] RF_DWELL = 4'h4;
  localparam logic [3:0] RF_CYCLES = 4'h5;
  localparam logic [3:0] RF_PTS = 4'h6;
  localparam logic [3:0] RF_PHASE = 4'h7;
  localparam logic [3:0] RF_LEVEL = 4'h8;
  localparam logic [3:0] RF_SFREQ = 4'h9;
  localparam logic [3:0] RF_ADC = 4'hA;
  // ********************
  // Saved configuration store
  // ********************
  localparam int NVM_AW = 2;
  localparam int NVM_DW = 32;
  localparam logic [1:0] NVM_LAST = 2'h2;
  localparam logic [1:0] LOAD_LAST = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DATA = 3'b001,
    ST_SKIP = 3'b010,
    ST_LIST = 3'b011,
    ST_SAVE = 3'b100,
    ST_LOAD = 3'b101
  } rscq_state_type;

  // Data bytes that follow each address byte
  function automatic logic [2:0] len_of(input logic [7:0] a);
    unique case (a)
      ADDR_SETUP, ADDR_LISTQ: len_of = 3'd3;
      ADDR_SFREQ: len_of = 3'd7;
      ADDR_SAVE, ADDR_SELFCAL, ADDR_RFQ, ADDR_TEMPQ, ADDR_STATQ,
      ADDR_INFOQ, ADDR_DACQ, ADDR_DRAIN, ADDR_SENSQ: len_of = 3'd1;
      default: len_of = 3'd0;
    endcase
  endfunction
endpackage

// ==== rtl/rscq_nvm.sv ====
// Nonvolatile store for the saved configuration words
module rscq_nvm
  import rscq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [NVM_AW-1:0] i_addr,
  input wire logic [NVM_DW-1:0] i_wdata,
  output logic [NVM_DW-1:0] o_rdata
);
  logic [NVM_DW-1:0] mem [0:(1<<NVM_AW)-1];

  // Blank store reads as zero; contents survive reset
  initial begin
    for (int i = 0; i < (1 << NVM_AW); i++) begin
      mem[i] = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule

// ==== test/rscq_host.sv ====
// Host model: writes framed register bytes and reads answers
module rscq_host (
  input wire logic i_clk,
  input wire logic i_rx_ready,
  output logic o_frame,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_rd_req,
  output logic o_fail
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_frame = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_byte = 8'hA5;
    o_rd_req = 1'b0;
    o_fail = 1'b0;
  end

  // Address byte, then n data bytes MSB first; each held until taken
  task automatic send(input logic [7:0] addr, input logic [63:0] data, input int n);
    logic [7:0] b;
    int t;
    @(posedge i_clk);
    #1;
    for (int k = 0; k <= n; k++) begin
      b = (k == 0) ? addr : data[8*(n-k) +: 8];
      o_frame = 1'b1;
      o_rx_valid = 1'b1;
      o_rx_byte = b;
      t = 0;
      @(negedge i_clk);
      while (i_rx_ready !== 1'b1 && t < 50) begin
        @(negedge i_clk);
        t++;
      end
      if (t >= 50) o_fail = 1'b1;
      @(posedge i_clk);
      #1;
    end
    // Released byte line shows the inverse of the last byte
    o_rx_valid = 1'b0;
    o_rx_byte = ~b;
    @(posedge i_clk);
    #1;
    o_frame = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  // Every answer read whole, after its query was written
  task automatic read8();
    o_rd_req = 1'b1;
    repeat (8) @(posedge i_clk);
    #1;
    o_rd_req = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
endmodule

// ==== test/test_rf_source_config_query_port.sv ====
// Self-checking bench of the configuration and query port
module test_rf_source_config_query_port;
  timeunit 1ns;
  timeprecision 100ps;
  import rscq_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic spi_sel, frame, rx_valid, rx_ready, rd_req, rd_valid, host_fail;
  logic [7:0] rx_byte, rd_byte;
  logic [55:0] cur_f, st_f, sp_f, stp_f, sen_freq, sfreq_w, f1;
  logic [31:0] dwell, cyc_cnt, pts, phase, level, temp, status, reading;
  logic [15:0] adc, dac_c, dac_f, sen_avg;
  logic [63:0] info, lentry;
  logic [23:0] s1;
  logic [11:0] list_addr, la;
  logic cal_start, cal_fine, sen_en, sen_env, busy, last_fine;
  int seed = 32'hdfd7;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int cal_n = 0;
  int busy_n = 0;
  int b0 = 0;
  logic [63:0] exp_q[$];

  always #2.5 clk = ~clk;

  rscq_port u_dut (.i_clk(clk), .i_rst(rst), .i_frame(frame), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte),
    .o_rx_ready(rx_ready), .i_spi_sel(spi_sel), .i_rd_req(rd_req), .o_rd_valid(rd_valid), .o_rd_byte(rd_byte),
    .i_cur_freq(cur_f), .i_sweep_start(st_f), .i_sweep_stop(sp_f), .i_sweep_step(stp_f), .i_dwell(dwell),
    .i_cycles(cyc_cnt), .i_list_pts(pts), .i_phase_float(phase), .i_level_float(level), .i_sensor_adc(adc),
    .i_temp_float(temp), .i_status(status), .i_info(info), .i_list_entry(lentry), .i_dac_coarse(dac_c),
    .i_dac_fine(dac_f), .i_sensor_reading(reading), .o_list_addr(list_addr), .o_cal_start(cal_start),
    .o_cal_fine(cal_fine), .o_sensor_enable(sen_en), .o_sensor_envelope(sen_env), .o_sensor_averages(sen_avg),
    .o_sensor_freq(sen_freq), .o_busy(busy));

  rscq_host u_host (.i_clk(clk), .i_rx_ready(rx_ready), .o_frame(frame), .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte), .o_rd_req(rd_req), .o_fail(host_fail));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [63:0] rnd();
    rnd = {$random(seed), $random(seed)};
  endfunction

  task automatic shake();
    {cur_f, st_f, sp_f, stp_f} = 224'({rnd(), rnd(), rnd(), rnd()});
    {dwell, cyc_cnt, pts, phase, level, temp, status, reading} = {rnd(), rnd(), rnd(), rnd()};
    {adc, dac_c, dac_f} = 48'(rnd());
    info = rnd();
    lentry = rnd();
  endtask

  function automatic logic [63:0] rf_exp(input logic [3:0] c);
    case (c)
      RF_CUR: rf_exp = 64'(cur_f);
      RF_START: rf_exp = 64'(st_f);
      RF_STOP: rf_exp = 64'(sp_f);
      RF_STEP: rf_exp = 64'(stp_f);
      RF_DWELL: rf_exp = 64'(dwell);
      RF_CYCLES: rf_exp = 64'(cyc_cnt);
      RF_PTS: rf_exp = 64'(pts);
      RF_PHASE: rf_exp = 64'(phase);
      RF_LEVEL: rf_exp = 64'(level);
      RF_SFREQ: rf_exp = 64'(sfreq_w);
      RF_ADC: rf_exp = 64'(adc);
      default: rf_exp = 64'h0;
    endcase
  endfunction

  // Query, drain on the serial path, then read all eight bytes
  task automatic ask(input logic [7:0] a, input logic [63:0] d, input int n, input logic [63:0] v);
    u_host.send(a, d, n);
    if (spi_sel) u_host.send(ADDR_DRAIN, 64'h0, 1);
    for (int k = 7; k >= 0; k--) exp_q.push_back(64'(v[8*k +: 8]));
    u_host.read8();
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask

  always @(negedge clk) begin
    if (busy === 1'b1 && rst === 1'b0) busy_n++;
    if (cal_start === 1'b1) begin
      cal_n++;
      last_fine = cal_fine;
    end
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check(64'(rd_byte), 64'h100);
      else check(64'(rd_byte), exp_q.pop_front());
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    spi_sel = 1'b0;
    shake();
    do_reset();
    check(64'({sen_avg, sen_env, sen_en}), 64'h0);
    check(64'(sen_freq), 64'h0);
    for (int f = 0; f < 2; f++) begin
      u_host.send(ADDR_SELFCAL, 64'(f), 1);
      check(64'({cal_n, last_fine}), 64'({f + 1, f[0]}));
    end
    s1 = 24'(rnd()) & 24'hFFFF03;
    u_host.send(ADDR_SETUP, 64'(s1), 3);
    check(64'({sen_avg, 6'h00, sen_env, sen_en}), 64'(s1));
    f1 = 56'(rnd());
    u_host.send(ADDR_SFREQ, 64'(f1), 7);
    check(64'(sen_freq), 64'(f1));
    b0 = busy_n;
    u_host.send(ADDR_SAVE, 64'h0, 1);
    check(64'(busy_n - b0), 64'h3);
    u_host.send(ADDR_SETUP, 64'h123402, 3);
    u_host.send(ADDR_SFREQ, rnd(), 7);
    u_host.send(ADDR_SAVE, 64'h5A, 1);
    check(64'({sen_avg, 6'h00, sen_env, sen_en}), 64'h123402);
    b0 = busy_n;
    do_reset();
    check(64'(busy_n - b0), 64'h4);
    check(64'({sen_avg, 6'h00, sen_env, sen_en}), 64'(s1));
    check(64'(sen_freq), 64'(f1));
    sfreq_w = f1;
    for (int c = 0; c < 16; c++) begin
      shake();
      spi_sel = c[0] ^ c[2];
      ask(ADDR_RFQ, 64'(c), 1, rf_exp(c[3:0]));
    end
    spi_sel = 1'b0;
    ask(ADDR_TEMPQ, 64'h0, 1, 64'(temp));
    ask(ADDR_STATQ, 64'h0, 1, 64'(status));
    ask(ADDR_INFOQ, 64'h0, 1, info);
    ask(ADDR_SENSQ, 64'h0, 1, 64'(reading));
    ask(ADDR_DACQ, 64'h0, 1, 64'(dac_c));
    spi_sel = 1'b1;
    ask(ADDR_DACQ, 64'h1, 1, 64'(dac_f));
    ask(ADDR_TEMPQ, 64'h0, 1, 64'(temp));
    ask(ADDR_DRAIN, 64'h0, 1, 64'h0);
    la = 12'(rnd());
    ask(ADDR_LISTQ, 64'({la[7:0], 4'h0, la[11:8], 8'h00}), 3, lentry);
    check(64'(list_addr), 64'(la));
    u_host.send(ADDR_RSVD, 64'h1C01, 2);
    check(64'(cal_n), 64'h2);
    check(64'(exp_q.size()), 64'h0);
    check(64'(host_fail), 64'h0);
    give_verdict();
  end
endmodule
